// ### core/osc_ctrl.sv
// Purpose: Oscillator select control register with source switching
// Assumes: Config bits are stable at reset release; strobes one cycle
// Notes:   Control register writes need the two-key unlock; aliases clear, set, invert
// Operation
// - Divider codes 0..7 divide the RC clock by 1..64 and 256; reset 1.
// - Divider select sits in bits 26:24, read and write.
// - Current source codes: RC, multiplier, primary, secondary, low-power.
// - Codes 110 and 111 act as divided RC; 011 is reserved.
// - Current source in bits 14:12, read-only, set only by hardware.
// - Reset loads current and next source from the initial-source config.
// - Reset loads switch request from the two-speed start config bit.
// - Reset loads secondary enable from its config bit.
// - Writes are ignored unless the unlock sequence was performed first.
// - Aliases at base plus 4, 8, C clear, set, invert written ones.
// - Bits 31:27, 23:15 and 11 always read zero.
// - Reset values depend on config bits and the reset type; here only on config bits, since the async reset clears divider and lock first.
// - Next source in bits 10:8, same encoding, software writable.
// - Switch request starts a switch to next source; cleared when done.
// - Lock bit blocks source selection changes while one.
// - Clock-fail flag sets when the monitor reports a failure.
//
// The plain strobed port and the address map were left to the implementer.
`timescale 1ns/1ps
module osc_ctrl
	import osc_pkg::*;
(
	// Clock and reset
	input wire logic CLK,
	input wire logic ARST_N,
	// Register port
	input wire logic [7:0] ADDR,
	input wire logic [31:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	output logic [31:0] RDATA,
	// Configuration word bits and reset kind
	input wire logic [2:0] CFG_INITIAL_SOURCE,
	input wire logic CFG_TWO_SPEED_START,
	input wire logic CFG_SECONDARY_ENABLE,
	input wire logic WAKE_RESET,
	// Fail-safe monitor
	input wire logic FAIL_DETECT,
	// Clock system outputs
	output logic [2:0] ACTIVE_SOURCE,
	output logic RC_TICK,
	output logic SECONDARY_ENABLE,
	output logic SLEEP_ON_WAIT,
	output logic SWITCH_BUSY,
	output logic IRQ
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	logic [2:0] div_ff;
	logic [2:0] cur_ff;
	logic [2:0] nxt_ff;
	logic lock_ff;
	logic sleep_ff;
	logic fail_ff;
	logic sec_en_ff;
	logic swreq_ff;
	logic cfg_pending_ff;
	osc_key_t key_ff;
	logic [1:0] stat_ff;
	logic [1:0] mask_ff;
	logic [31:0] rdata_ff;
	logic sw_busy;
	logic sw_done;
	logic [31:0] ctrl_rd;
	logic [31:0] nxt_ctrl;
	logic ctrl_hit;
	logic ctrl_wr;
	logic sel_ok;

	// ----------------------------------------------------------------
	// Control register view and alias write merge
	// ----------------------------------------------------------------
	always_comb begin
		ctrl_rd = 32'h0000_0000;
		ctrl_rd[DIV_LSB +: 3] = div_ff;
		ctrl_rd[CUR_LSB +: 3] = cur_ff;
		ctrl_rd[NXT_LSB +: 3] = nxt_ff;
		ctrl_rd[LOCK_BIT] = lock_ff;
		ctrl_rd[SLEEP_BIT] = sleep_ff;
		ctrl_rd[FAIL_BIT] = fail_ff;
		ctrl_rd[SEC_EN_BIT] = sec_en_ff;
		ctrl_rd[SWREQ_BIT] = swreq_ff;
	end

	assign ctrl_hit = (ADDR == OFS_CTRL) || (ADDR == OFS_CTRL_CLR)
		|| (ADDR == OFS_CTRL_SET) || (ADDR == OFS_CTRL_INV);
	assign ctrl_wr = WR && ctrl_hit && (key_ff == KEY_OPEN);

	always_comb begin
		unique case (ADDR)
			OFS_CTRL_CLR: nxt_ctrl = ctrl_rd & ~WDATA;
			OFS_CTRL_SET: nxt_ctrl = ctrl_rd | WDATA;
			OFS_CTRL_INV: nxt_ctrl = ctrl_rd ^ WDATA;
			default: nxt_ctrl = WDATA;
		endcase
		nxt_ctrl = (nxt_ctrl & CTRL_WMASK) | (ctrl_rd & ~CTRL_WMASK);
	end

	// Source selection may change only while unlocked and no switch runs
	assign sel_ok = ctrl_wr && !lock_ff;

	// ----------------------------------------------------------------
	// Unlock sequence
	// ----------------------------------------------------------------
	// Any other key value relocks, so a stray write cannot reopen it
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			key_ff <= KEY_LOCKED;
		end else if (WR && ADDR == OFS_KEY) begin
			unique case (key_ff)
				KEY_LOCKED: key_ff <= (WDATA == KEY_FIRST) ? KEY_HALF
					: KEY_LOCKED;
				KEY_HALF: key_ff <= (WDATA == KEY_SECOND) ? KEY_OPEN
					: KEY_LOCKED;
				KEY_OPEN: key_ff <= (WDATA == KEY_FIRST) ? KEY_HALF
					: KEY_LOCKED;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Configuration capture after reset release
	// ----------------------------------------------------------------
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			cfg_pending_ff <= 1'b1;
		end else begin
			cfg_pending_ff <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Source selection and switch request
	// ----------------------------------------------------------------
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			cur_ff <= SRC_RC_DIV;
			nxt_ff <= SRC_RC_DIV;
		end else if (cfg_pending_ff) begin
			cur_ff <= CFG_INITIAL_SOURCE;
			nxt_ff <= CFG_INITIAL_SOURCE;
		end else begin
			if (sw_done) begin
				cur_ff <= nxt_ff;
			end
			if (sel_ok && !swreq_ff) begin
				nxt_ff <= nxt_ctrl[NXT_LSB +: 3];
			end
		end
	end

	// Request clears one cycle after the current source was updated
	logic clear_req_ff;
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			swreq_ff <= 1'b0;
			clear_req_ff <= 1'b0;
		end else if (cfg_pending_ff) begin
			swreq_ff <= CFG_TWO_SPEED_START;
			clear_req_ff <= 1'b0;
		end else begin
			clear_req_ff <= sw_done;
			if (clear_req_ff) begin
				swreq_ff <= 1'b0;
			end else if (sel_ok && !swreq_ff) begin
				swreq_ff <= nxt_ctrl[SWREQ_BIT];
			end
		end
	end

	osc_switch_seq #(
		.CYCLES(SWITCH_CYCLES)
	) u_switch (
		.clk(CLK),
		.arst_n(ARST_N),
		.start(swreq_ff && !clear_req_ff),
		.busy(sw_busy),
		.done(sw_done)
	);

	// ----------------------------------------------------------------
	// Divider, lock, sleep and secondary enable
	// ----------------------------------------------------------------
	// Divider and lock clear on every reset, wake or not; the async reset clears them before the wake check
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			div_ff <= DIV_RESET;
			lock_ff <= 1'b0;
			sleep_ff <= 1'b0;
			sec_en_ff <= 1'b0;
		end else if (cfg_pending_ff) begin
			sec_en_ff <= CFG_SECONDARY_ENABLE;
			if (!WAKE_RESET) begin
				div_ff <= DIV_RESET;
				lock_ff <= 1'b0;
			end
		end else if (ctrl_wr) begin
			div_ff <= nxt_ctrl[DIV_LSB +: 3];
			sleep_ff <= nxt_ctrl[SLEEP_BIT];
			sec_en_ff <= nxt_ctrl[SEC_EN_BIT];
			// Lock can only be set; reset is the way out
			lock_ff <= lock_ff | nxt_ctrl[LOCK_BIT];
		end
	end

	// ----------------------------------------------------------------
	// Clock-fail flag: hardware set wins over software clear
	// ----------------------------------------------------------------
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			fail_ff <= 1'b0;
		end else if (FAIL_DETECT) begin
			fail_ff <= 1'b1;
		end else if (ctrl_wr) begin
			fail_ff <= nxt_ctrl[FAIL_BIT];
		end
	end

	// ----------------------------------------------------------------
	// Interrupt status and mask
	// ----------------------------------------------------------------
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			stat_ff <= 2'h0;
		end else begin
			for (int i = 0; i < 2; i++) begin
				if ((i == IRQ_DONE_BIT && sw_done)
					|| (i == IRQ_FAIL_BIT && FAIL_DETECT)) begin
					stat_ff[i] <= 1'b1;
				end else if (WR && ADDR == OFS_IRQ_STAT && WDATA[i]) begin
					stat_ff[i] <= 1'b0;
				end
			end
		end
	end

	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			mask_ff <= IRQ_MASK_RESET;
		end else if (WR && ADDR == OFS_IRQ_MASK) begin
			mask_ff <= WDATA[1:0];
		end
	end

	assign IRQ = |(stat_ff & mask_ff);

	// ----------------------------------------------------------------
	// Read port: data in the cycle after the strobe, else zero
	// ----------------------------------------------------------------
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			rdata_ff <= 32'h0000_0000;
		end else if (RD) begin
			unique case (ADDR)
				OFS_CTRL: rdata_ff <= ctrl_rd;
				OFS_KEY: rdata_ff <= {30'h0, key_ff};
				OFS_IRQ_STAT: rdata_ff <= {30'h0, stat_ff};
				OFS_IRQ_MASK: rdata_ff <= {30'h0, mask_ff};
				default: rdata_ff <= 32'h0000_0000;
			endcase
		end else begin
			rdata_ff <= 32'h0000_0000;
		end
	end

	assign RDATA = rdata_ff;

	// ----------------------------------------------------------------
	// Clock system outputs
	// ----------------------------------------------------------------
	// Reserved codes fall back to the divided fast RC
	always_comb begin
		unique case (cur_ff)
			SRC_MULT_LOOP, SRC_PRIMARY, SRC_SECONDARY, SRC_LOW_POWER:
				ACTIVE_SOURCE = cur_ff;
			default: ACTIVE_SOURCE = SRC_RC_DIV;
		endcase
	end

	osc_rc_divider u_div (
		.clk(CLK),
		.arst_n(ARST_N),
		.div_code(div_ff),
		.tick(RC_TICK)
	);

	assign SECONDARY_ENABLE = sec_en_ff;
	assign SLEEP_ON_WAIT = sleep_ff;
	assign SWITCH_BUSY = sw_busy;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!ARST_N);

	a_locked_write_ignored: assert property (
		(WR && ctrl_hit && key_ff != KEY_OPEN && !cfg_pending_ff
		&& !FAIL_DETECT && !sw_done) |=> $stable(div_ff)
		&& $stable(sleep_ff) && $stable(sec_en_ff))
		else $error("Control changed without unlock");
	a_cur_readonly: assert property (
		!sw_done && !cfg_pending_ff |=> $stable(cur_ff))
		else $error("Current source changed without a switch");
	a_switch_order: assert property (
		sw_done |=> cur_ff == $past(nxt_ff) ##1 !swreq_ff)
		else $error("Switch request cleared out of order");
	a_switch_time: assert property (
		$rose(sw_busy) |-> sw_busy [*8] ##[1:4] sw_done)
		else $error("Switch did not complete in time");
	a_fail_sets: assert property (
		FAIL_DETECT |=> fail_ff && stat_ff[IRQ_FAIL_BIT])
		else $error("Clock fail not flagged");
	a_lock_holds: assert property (
		lock_ff && !cfg_pending_ff |=> $stable(nxt_ff) && lock_ff)
		else $error("Selection changed while locked");
	a_reserved_zero: assert property (
		RD ##1 1'b1 |-> RDATA[31:27] == 5'h00
		&& RDATA[23:15] == 9'h000 && RDATA[11] == 1'b0)
		else $error("Unimplemented bits read nonzero");
	// Checked on the edge after the load; the release edge itself is
	// skipped, since the flops still held reset values when it was sampled
	a_reset_config: assert property (
		$fell(cfg_pending_ff) |-> nxt_ff == $past(CFG_INITIAL_SOURCE)
		&& cur_ff == $past(CFG_INITIAL_SOURCE)
		&& swreq_ff == $past(CFG_TWO_SPEED_START)
		&& sec_en_ff == $past(CFG_SECONDARY_ENABLE))
		else $error("Reset values not loaded from config");
	a_set_alias: assert property (
		ctrl_wr && ADDR == OFS_CTRL_SET && !cfg_pending_ff
		&& WDATA[SLEEP_BIT] |=> sleep_ff)
		else $error("Set alias did not set the bit");
	a_reserved_src: assert property (
		cur_ff[2:1] == 2'h3 || cur_ff == 3'h3
		|-> ACTIVE_SOURCE == SRC_RC_DIV)
		else $error("Reserved source not mapped to fast RC");

	c_switch_done: cover property (sw_done ##2 !swreq_ff);
	c_unlock_write: cover property (key_ff == KEY_OPEN && ctrl_wr);
	c_fail_irq: cover property (FAIL_DETECT ##1 IRQ);
	c_slow_div: cover property (div_ff == 3'h7 && RC_TICK);

endmodule

// ### shared/osc_pkg.sv
// Purpose: Shared constants and types of the oscillator source control block
// Assumes: 100 MHz system clock, 8-bit byte address on the register port
// Notes:   Alias words of the control register clear, set or invert bits
package osc_pkg;

	// ----------------------------------------------------------------
	// Clock and timing
	// ----------------------------------------------------------------
	localparam int CLK_MHZ = 100;
	localparam int SWITCH_TIME_NS = 100;
	localparam int SWITCH_CYCLES =
		(SWITCH_TIME_NS * CLK_MHZ + 999) / 1000;

	// ----------------------------------------------------------------
	// Register map (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_CTRL_CLR = 8'h04;
	localparam logic [7:0] OFS_CTRL_SET = 8'h08;
	localparam logic [7:0] OFS_CTRL_INV = 8'h0C;
	localparam logic [7:0] OFS_KEY = 8'h30;
	localparam logic [7:0] OFS_IRQ_STAT = 8'h40;
	localparam logic [7:0] OFS_IRQ_MASK = 8'h50;

	// ----------------------------------------------------------------
	// Control register fields
	// ----------------------------------------------------------------
	localparam int DIV_LSB = 24;
	localparam int CUR_LSB = 12;
	localparam int NXT_LSB = 8;
	localparam int LOCK_BIT = 7;
	localparam int SLEEP_BIT = 4;
	localparam int FAIL_BIT = 3;
	localparam int SEC_EN_BIT = 1;
	localparam int SWREQ_BIT = 0;
	// Software-writable bits; the current source field is read-only
	localparam logic [31:0] CTRL_WMASK = 32'h0700_079B;

	// Interrupt status bits
	localparam int IRQ_DONE_BIT = 0;
	localparam int IRQ_FAIL_BIT = 1;

	// ----------------------------------------------------------------
	// Unlock keys and reset values
	// ----------------------------------------------------------------
	localparam logic [31:0] KEY_FIRST = 32'hAA99_6655;
	localparam logic [31:0] KEY_SECOND = 32'h5566_99AA;
	localparam logic [2:0] DIV_RESET = 3'h0;
	localparam logic [1:0] IRQ_MASK_RESET = 2'h0;

	// ----------------------------------------------------------------
	// Source codes
	// ----------------------------------------------------------------
	localparam logic [2:0] SRC_RC_DIV = 3'h0;
	localparam logic [2:0] SRC_MULT_LOOP = 3'h1;
	localparam logic [2:0] SRC_PRIMARY = 3'h2;
	localparam logic [2:0] SRC_SECONDARY = 3'h4;
	localparam logic [2:0] SRC_LOW_POWER = 3'h5;

	typedef enum logic [1:0] {
		KEY_LOCKED,
		KEY_HALF,
		KEY_OPEN
	} osc_key_t;

endpackage

// ### core/osc_frc_divider.sv
// Purpose: One-cycle enable pulses at the divided fast RC rate
// Assumes: The fast RC clock is modelled by the system clock
// Notes:   A new code takes effect at once; a count already past its end wraps next cycle
`timescale 1ns/1ps
module osc_rc_divider
	import osc_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// Divider select
	input wire logic [2:0] div_code,
	// Output
	output logic tick
);

	logic [7:0] cnt_ff;
	logic [7:0] last;

	// Divide by 1, 2, 4, 8, 16, 32, 64, 256 for codes 0 to 7
	always_comb begin
		unique case (div_code)
			3'h0: last = 8'h00;
			3'h1: last = 8'h01;
			3'h2: last = 8'h03;
			3'h3: last = 8'h07;
			3'h4: last = 8'h0F;
			3'h5: last = 8'h1F;
			3'h6: last = 8'h3F;
			3'h7: last = 8'hFF;
		endcase
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			cnt_ff <= 8'h00;
		end else if (cnt_ff >= last) begin
			cnt_ff <= 8'h00;
		end else begin
			cnt_ff <= cnt_ff + 8'h01;
		end
	end

	assign tick = (cnt_ff >= last);

endmodule

// ### core/osc_switch_seq.sv
// Purpose: Times one clock source switch and reports its end
// Assumes: start is held until done has been seen
// Notes:   done is a one-cycle pulse; busy covers the whole wait
`timescale 1ns/1ps
module osc_switch_seq
	import osc_pkg::*;
#(
	parameter int CYCLES = SWITCH_CYCLES
)
(
	// Clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// Control
	input wire logic start,
	output logic busy,
	output logic done
);

	logic [15:0] cnt_ff;
	logic busy_ff;
	logic done_ff;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			busy_ff <= 1'b0;
			done_ff <= 1'b0;
			cnt_ff <= 16'h0000;
		end else begin
			done_ff <= 1'b0;
			if (!busy_ff && start && !done_ff) begin
				busy_ff <= 1'b1;
				cnt_ff <= 16'h0000;
			end else if (busy_ff) begin
				if (cnt_ff == 16'(CYCLES - 1)) begin
					busy_ff <= 1'b0;
					done_ff <= 1'b1;
				end else begin
					cnt_ff <= cnt_ff + 16'h0001;
				end
			end
		end
	end

	assign busy = busy_ff;
	assign done = done_ff;

endmodule

// ### verif/testbench.sv
// Purpose: Self-checking bench of the oscillator source control block
// Assumes: Switch timer of ten cycles; config sampled at reset release
// Notes:   Reads queue their expected word; a monitor compares RDATA
`timescale 1ns/1ps
module testbench;
	import osc_pkg::*;

	// ----------------------------------------------------------------
	// Signals
	// ----------------------------------------------------------------
	logic clk;
	logic arst_n;
	logic wr;
	logic rd;
	logic ts_cfg;
	logic sec_cfg;
	logic wake;
	logic fail;
	logic [7:0] addr;
	logic [31:0] wdata;
	logic [31:0] rdata;
	logic [31:0] ec;
	logic [2:0] src_cfg;
	logic [2:0] act;
	logic [2:0] ea;
	logic tick;
	logic sec_en;
	logic slp;
	logic busy;
	logic irq;
	logic rd_seen;
	logic [31:0] exp_q[$];
	logic [2:0] codes [8] = '{3'h1, 3'h2, 3'h4, 3'h5, 3'h3, 3'h6, 3'h7, 3'h0};
	integer seed = 32'h80FB;
	int miscompares = 0;
	int num_checks = 0;
	int cycles = 0;

	osc_ctrl osc_ctrl_i (
		.CLK(clk),
		.ARST_N(arst_n),
		.ADDR(addr),
		.WDATA(wdata),
		.WR(wr),
		.RD(rd),
		.RDATA(rdata),
		.CFG_INITIAL_SOURCE(src_cfg),
		.CFG_TWO_SPEED_START(ts_cfg),
		.CFG_SECONDARY_ENABLE(sec_cfg),
		.WAKE_RESET(wake),
		.FAIL_DETECT(fail),
		.ACTIVE_SOURCE(act),
		.RC_TICK(tick),
		.SECONDARY_ENABLE(sec_en),
		.SLEEP_ON_WAIT(slp),
		.SWITCH_BUSY(busy),
		.IRQ(irq)
	);

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// ----------------------------------------------------------------
	// Checking and closing
	// ----------------------------------------------------------------
	task automatic check(input string name, input logic [31:0] seen,
		input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	// Read data stand only in the cycle after the strobe
	always @(posedge clk) begin
		rd_seen <= rd;
	end

	always @(negedge clk) begin
		if (rd_seen === 1'b1) begin
			if (exp_q.size() == 0) begin
				check("rdata queue", 32'h1, 32'h0);
			end else begin
				check("rdata", rdata, exp_q.pop_front());
			end
		end
	end

	// Whole run needs about 1500 cycles
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			miscompares++;
			tally_and_finish();
		end
	end

	// ----------------------------------------------------------------
	// Drivers
	// ----------------------------------------------------------------
	task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
	endtask

	task automatic bus_rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		exp_q.push_back(e);
		@(posedge clk);
		rd <= 1'b0;
	endtask

	task automatic unlock();
		bus_wr(OFS_KEY, KEY_FIRST);
		bus_wr(OFS_KEY, KEY_SECOND);
	endtask

	task automatic alias_wr(input logic [7:0] a, input logic [31:0] d);
		bus_wr(a, d);
		case (a)
			OFS_CTRL_CLR: ec = ec & ~d;
			OFS_CTRL_SET: ec = ec | d;
			default: ec = ec ^ d;
		endcase
		bus_rd(OFS_CTRL, ec);
	endtask

	task automatic do_reset(input logic [2:0] s, input logic t,
		input logic e);
		arst_n <= 1'b0;
		src_cfg <= s;
		ts_cfg <= t;
		sec_cfg <= e;
		repeat (16) @(posedge clk);
		check("tick in reset", {31'h0, tick}, 32'h1);
		arst_n <= 1'b1;
	endtask

	task automatic wait_busy(input logic lvl);
		int n;
		// Looked at mid-cycle, never on the edge that launches it
		n = 0;
		@(negedge clk);
		while (busy !== lvl && n < 40) begin
			@(negedge clk);
			n++;
		end
		check("busy", {31'h0, busy}, {31'h0, lvl});
	endtask

	// Skip two ticks so the new code is in force, then time one period
	task automatic tick_period(input int ratio);
		int n;
		repeat (2) begin
			n = 0;
			@(negedge clk);
			while (tick !== 1'b1 && n < 600) begin
				@(negedge clk);
				n++;
			end
		end
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (tick !== 1'b1 && n < 600);
		check("tick period", 32'(n), 32'(ratio));
	endtask

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		arst_n = 1'b0;
		wr = 1'b0;
		rd = 1'b0;
		addr = 8'h00;
		wdata = 32'h0;
		wake = 1'b0;
		fail = 1'b0;
		src_cfg = 3'h0;
		ts_cfg = 1'b0;
		sec_cfg = 1'b0;
		do_reset(3'h2, 1'b0, 1'b1);
		ec = 32'h0000_2202;
		bus_rd(OFS_CTRL, ec);
		@(negedge clk);
		check("active", {29'h0, act}, 32'h2);
		bus_rd(OFS_IRQ_MASK, 32'h0);
		bus_rd(8'h20, 32'h0);
		bus_rd(OFS_CTRL_SET, 32'h0);
		// Locked writes and a broken key sequence must change nothing
		bus_wr(OFS_CTRL, $random(seed));
		bus_wr(OFS_KEY, KEY_FIRST);
		bus_wr(OFS_KEY, KEY_SECOND ^ 32'h1);
		bus_wr(OFS_CTRL_INV, $random(seed));
		bus_rd(OFS_CTRL, ec);
		unlock();
		bus_wr(OFS_CTRL, 32'hFFFF_FA12);
		ec = 32'h0700_2212;
		bus_rd(OFS_CTRL, ec);
		@(negedge clk);
		check("sleep", {31'h0, slp}, 32'h1);
		check("secondary enable", {31'h0, sec_en}, 32'h1);
		for (int i = 0; i < 8; i++) begin
			ec[26:24] = 3'(i);
			bus_wr(OFS_CTRL, ec);
			tick_period(i < 7 ? 1 << i : 256);
		end
		bus_rd(OFS_CTRL, ec);
		alias_wr(OFS_CTRL_CLR, 32'h0500_0010);
		alias_wr(OFS_CTRL_SET, 32'h0000_0010);
		alias_wr(OFS_CTRL_INV, 32'h0300_0002);
		foreach (codes[k]) begin
			bus_wr(OFS_CTRL, (ec & ~32'h0000_0701) | {21'h0, codes[k], 8'h01});
			wait_busy(1'b1);
			wait_busy(1'b0);
			repeat (4) @(posedge clk);
			ec[14:12] = codes[k];
			ec[10:8] = codes[k];
			bus_rd(OFS_CTRL, ec);
			ea = (codes[k] == 3'h3 || codes[k] > 3'h5) ? 3'h0 : codes[k];
			@(negedge clk);
			check("active", {29'h0, act}, {29'h0, ea});
		end
		bus_rd(OFS_IRQ_STAT, 32'h1);
		check("irq masked", {31'h0, irq}, 32'h0);
		bus_wr(OFS_IRQ_MASK, 32'h3);
		@(negedge clk);
		check("irq", {31'h0, irq}, 32'h1);
		bus_wr(OFS_IRQ_STAT, 32'h1);
		@(negedge clk);
		check("irq", {31'h0, irq}, 32'h0);
		@(posedge clk);
		fail <= 1'b1;
		@(posedge clk);
		fail <= 1'b0;
		ec[3] = 1'b1;
		@(negedge clk);
		check("irq fail", {31'h0, irq}, 32'h1);
		bus_rd(OFS_IRQ_STAT, 32'h2);
		bus_rd(OFS_CTRL, ec);
		bus_wr(OFS_IRQ_STAT, 32'h2);
		bus_wr(OFS_IRQ_MASK, 32'h1);
		fail <= 1'b1;
		@(posedge clk);
		fail <= 1'b0;
		@(negedge clk);
		check("irq masked", {31'h0, irq}, 32'h0);
		// Locked: next source, request and the lock itself stay put
		alias_wr(OFS_CTRL_SET, 32'h0000_0080);
		bus_wr(OFS_CTRL, (ec & ~32'h0000_0701) | 32'h0000_0101);
		bus_wr(OFS_CTRL_CLR, 32'h0000_0080);
		bus_rd(OFS_CTRL, ec);
		@(negedge clk);
		check("busy locked", {31'h0, busy}, 32'h0);
		do_reset(3'h5, 1'b1, 1'b0);
		bus_rd(OFS_CTRL, 32'h0000_5501);
		wait_busy(1'b1);
		wait_busy(1'b0);
		repeat (4) @(posedge clk);
		bus_rd(OFS_CTRL, 32'h0000_5500);
		repeat (2) @(posedge clk);
		tally_and_finish();
	end
endmodule
